//--- hdl/mcr_regs.sv
// mcr_regs: statistics counters, pause, wake and delay control registers
//
// Our own choice: the Avalon-MM register port.
module mcr_regs (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // avalon-mm slave
    input  wire mcr_pkg::mcr_av_req_t av,
    output logic [31:0]             readdata,
    output logic                    waitrequest,
    // events from the datapath, same clock
    input  wire mcr_pkg::mcr_evt_t  ev,
    // controls toward the datapath
    output logic [6:0]              peek_block,
    output logic                    tx_hold,
    output logic                    host_not_responding_reply,
    output logic                    irq
);
    import mcr_pkg::*;

    typedef struct packed {
        logic [NCNT-1:0][31:0] cnt;
        logic [NCNT-1:0][15:0] pend;
        logic                  ainc;
        logic                  cor;
        logic                  wmode;
        logic [5:0]            sel;
        logic                  frz;
        logic [6:0]            peek;
        logic [23:0]           idly;
        logic [15:0]           pval;
        logic [31:0]           hto;
        logic [7:0]            wcls;
        logic                  rxd_run;
        logic [23:0]           rxd_cnt;
        logic                  hold;
        logic [15:0]           q_cnt;
        logic [8:0]            bit_cnt;
        logic                  hto_run;
        logic [31:0]           hto_cnt;
        logic                  nresp;
        logic [NIRQ-1:0]       ist;
        logic [NIRQ-1:0]       imsk;
        logic                  irq;
        logic                  wait_r;
        logic [31:0]           rdata;
    } mcr_state_t;

    mcr_state_t s_ff;
    mcr_state_t nxt_s;

    logic            req;
    logic            acc;
    logic            wr;
    logic            rd;
    logic            cdat_wr;
    logic            cdat_rd;
    logic            cdat_acc;
    logic            clr_rx;
    logic            clr_tx;
    logic [NIRQ-1:0] ist_set;
    logic [31:0]     rword;

    // counter index is a transmit one up to the last transmit slot
    function automatic logic is_tx(input int idx);
        return 6'(idx) <= LAST_TX;
    endfunction

    // ========================================================
    // bus decode; a request is taken on the edge where wait is low
    assign req     = av.read | av.write;
    assign acc     = req & ~s_ff.wait_r;
    assign wr      = acc & av.write;
    assign rd      = acc & av.read;
    assign cdat_acc = acc & (av.address == OFF_CDATA);
    assign cdat_wr  = cdat_acc & av.write & s_ff.wmode;
    assign cdat_rd  = cdat_acc & av.read & ~s_ff.wmode;
    assign clr_rx  = wr & (av.address == OFF_CMGT)
                   & av.writedata[CM_CLRX];
    assign clr_tx  = wr & (av.address == OFF_CMGT)
                   & av.writedata[CM_CLTX];

    // ========================================================
    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rword = RST_WORD;
        case (av.address)
            OFF_CDATA: begin
                if (s_ff.sel <= LAST_CNT) begin
                    rword = s_ff.cnt[s_ff.sel];
                end
            end
            OFF_CCTL: begin
                rword[CC_AINC]  = s_ff.ainc;
                rword[CC_COR]   = s_ff.cor;
                rword[CC_WMODE] = s_ff.wmode;
                rword[5:0]      = s_ff.sel;
            end
            OFF_CMGT:  rword[CM_FRZ] = s_ff.frz;
            OFF_PEEK:  rword[6:0]    = s_ff.peek;
            OFF_IDLY:  rword[23:0]   = s_ff.idly;
            OFF_PAUSE: rword[15:0]   = s_ff.pval;
            OFF_HTO:   rword         = s_ff.hto;
            OFF_WAKE:  rword[7:0]    = s_ff.wcls;
            OFF_IST:   rword[NIRQ-1:0] = s_ff.ist;
            OFF_IMSK:  rword[NIRQ-1:0] = s_ff.imsk;
            default:   rword = RST_WORD;
        endcase
    end

    // ========================================================
    // next-state logic for the whole block
    always_comb begin
        nxt_s   = s_ff;
        ist_set = '0;

        // wait is low exactly one cycle after a request is seen
        nxt_s.wait_r = ~(req & s_ff.wait_r);
        if (req & s_ff.wait_r) begin
            nxt_s.rdata = rword;
        end

        // plain control registers
        if (wr) begin
            case (av.address)
                OFF_CCTL: begin
                    nxt_s.ainc  = av.writedata[CC_AINC];
                    nxt_s.cor   = av.writedata[CC_COR];
                    nxt_s.wmode = av.writedata[CC_WMODE];
                    nxt_s.sel   = av.writedata[5:0];
                end
                OFF_CMGT:  nxt_s.frz  = av.writedata[CM_FRZ];
                OFF_PEEK:  nxt_s.peek = av.writedata[6:0];
                OFF_IDLY:  nxt_s.idly = av.writedata[23:0];
                OFF_PAUSE: nxt_s.pval = av.writedata[15:0];
                OFF_HTO:   nxt_s.hto  = av.writedata;
                OFF_IMSK:  nxt_s.imsk = av.writedata[NIRQ-1:0];
                default: ;
            endcase
        end

        // with auto increment set, index steps after every data access, wrapping past the last
        if (cdat_acc & s_ff.ainc) begin
            nxt_s.sel = (s_ff.sel >= LAST_CNT) ? 6'h00
                                               : s_ff.sel + 6'h01;
        end

        // counters: loads and clears act even while frozen, since
        // software asked for them; only events are parked
        for (int i = 0; i < NCNT; i++) begin
            logic clr;
            logic ld;
            logic inc;
            clr = (is_tx(i) ? clr_tx : clr_rx)
                | (cdat_rd & s_ff.cor & (s_ff.sel == 6'(i)));
            ld  = cdat_wr & (s_ff.sel == 6'(i));
            inc = ev.cnt_evt[i];
            if (s_ff.frz) begin
                if (ld) begin
                    nxt_s.cnt[i] = av.writedata;
                end else if (clr) begin
                    nxt_s.cnt[i] = RST_WORD;
                end
                if (clr | ld) begin
                    nxt_s.pend[i] = '0;
                end else if (inc) begin
                    nxt_s.pend[i] = s_ff.pend[i] + 16'h0001;
                end
            end else begin
                // set wins: an event in the clearing cycle survives
                if (ld) begin
                    nxt_s.cnt[i] = av.writedata;
                end else if (clr) begin
                    nxt_s.cnt[i] = {31'h0, inc};
                end else begin
                    nxt_s.cnt[i] = s_ff.cnt[i] + 32'(s_ff.pend[i])
                                 + 32'(inc);
                end
                nxt_s.pend[i] = '0;
            end
        end

        // delayed receive-data interrupt; later events merge in
        if (s_ff.rxd_run) begin
            if (s_ff.rxd_cnt == 24'h0) begin
                nxt_s.rxd_run    = 1'b0;
                ist_set[IRQ_RXD] = 1'b1;
            end else if (ev.byte_tick) begin
                nxt_s.rxd_cnt = s_ff.rxd_cnt - 24'h1;
            end
        end else if (ev.rx_data) begin
            nxt_s.rxd_run = 1'b1;
            nxt_s.rxd_cnt = s_ff.idly;
        end

        // local pause: quanta of 512 receive bit times
        if (wr & (av.address == OFF_PAUSE)
            & av.writedata[PD_START]) begin
            nxt_s.hold    = 1'b1;
            nxt_s.q_cnt   = av.writedata[15:0];
            nxt_s.bit_cnt = '0;
        end else if (s_ff.hold) begin
            if (s_ff.q_cnt == 16'h0) begin
                nxt_s.hold        = 1'b0;
                ist_set[IRQ_PEND] = 1'b1;
            end else if (ev.rx_bit_tick) begin
                if (s_ff.bit_cnt == QBIT_LAST) begin
                    nxt_s.bit_cnt = '0;
                    nxt_s.q_cnt   = s_ff.q_cnt - 16'h1;
                end else begin
                    nxt_s.bit_cnt = s_ff.bit_cnt + 9'h1;
                end
            end
        end

        // host response watchdog after a wake condition
        nxt_s.nresp = 1'b0;
        if (ev.wake) begin
            nxt_s.wcls         = ev.wake_class;
            nxt_s.hto_run      = 1'b1;
            nxt_s.hto_cnt      = s_ff.hto;
            ist_set[IRQ_WAKE]  = 1'b1;
        end else if (s_ff.hto_run) begin
            if (ev.host_ack) begin
                nxt_s.hto_run = 1'b0;
            end else if (s_ff.hto_cnt == 32'h0) begin
                nxt_s.hto_run    = 1'b0;
                nxt_s.nresp         = 1'b1;
                ist_set[IRQ_NORESP] = 1'b1;
            end else begin
                nxt_s.hto_cnt = s_ff.hto_cnt - 32'h1;
            end
        end

        // sticky status, write one to clear, a new event wins
        if (wr & (av.address == OFF_IST)) begin
            nxt_s.ist = s_ff.ist & ~av.writedata[NIRQ-1:0];
        end
        nxt_s.ist = nxt_s.ist | ist_set;
        nxt_s.irq = |(s_ff.ist & s_ff.imsk);
    end

    // ========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff        <= '0;
            s_ff.wait_r <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign readdata    = s_ff.rdata;
    assign waitrequest = s_ff.wait_r;
    assign peek_block  = s_ff.peek;
    assign tx_hold     = s_ff.hold;
    assign host_not_responding_reply = s_ff.nresp;
    assign irq         = s_ff.irq;

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wake_no_wait_s;
        ev.wake && s_ff.hto == 32'h0;
    endsequence
    sequence no_ack_s;
        !ev.host_ack && !ev.wake;
    endsequence
    sequence pause_go_s;
        wr && av.address == OFF_PAUSE && av.writedata[PD_START];
    endsequence

    bus_one_wait_a: assert property (req && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    auto_step_a: assert property (
        cdat_acc && s_ff.ainc && s_ff.sel < LAST_CNT && !wr
        |=> s_ff.sel == $past(s_ff.sel) + 6'h01)
        else $error("counter index did not step");
    read_clear_a: assert property (
        cdat_rd && s_ff.cor && !s_ff.frz
        |=> s_ff.cnt[$past(s_ff.sel)] <= 32'h1)
        else $error("counter not cleared on read");
    write_load_a: assert property (
        cdat_wr && s_ff.sel <= LAST_CNT
        |=> s_ff.cnt[$past(s_ff.sel)] == $past(av.writedata))
        else $error("counter not loaded by write");
    // a clear-on-read is software's own request and acts while frozen
    freeze_hold_a: assert property (
        s_ff.frz && !wr && !(cdat_rd && s_ff.cor)
        |=> s_ff.cnt == $past(s_ff.cnt))
        else $error("counter moved while frozen");
    freeze_queue_a: assert property (
        s_ff.frz && !wr && !cdat_rd && ev.cnt_evt[16]
        && s_ff.pend[16] != 16'hffff
        |=> s_ff.pend[16] == $past(s_ff.pend[16]) + 16'h0001)
        else $error("frozen event not queued");
    clear_rx_a: assert property (
        clr_rx && !s_ff.frz |=> s_ff.cnt[16] <= 32'h1)
        else $error("receive counter not cleared");
    rx_delay_a: assert property (
        ev.rx_data && !s_ff.rxd_run && s_ff.idly == 24'h0
        |-> ##2 s_ff.ist[IRQ_RXD])
        else $error("undelayed receive interrupt missing");
    pause_start_a: assert property (pause_go_s |=> tx_hold)
        else $error("pause did not start");
    no_reply_a: assert property (
        wake_no_wait_s ##1 no_ack_s |=> host_not_responding_reply)
        else $error("host-not-responding reply missing");
    wake_class_a: assert property (
        ev.wake |=> s_ff.wcls == $past(ev.wake_class))
        else $error("wake class not captured");
endmodule

//--- shared/mcr_pkg.sv
// mcr_pkg: offsets, fields, reset values and carriers of the counter, pause, wake and delay regs
package mcr_pkg;
    // ========================================================
    // register byte offsets
    localparam logic [8:0] OFF_CDATA = 9'h164;
    localparam logic [8:0] OFF_CCTL  = 9'h168;
    localparam logic [8:0] OFF_CMGT  = 9'h16c;
    localparam logic [8:0] OFF_PEEK  = 9'h170;
    localparam logic [8:0] OFF_IDLY  = 9'h180;
    localparam logic [8:0] OFF_PAUSE = 9'h184;
    localparam logic [8:0] OFF_HTO   = 9'h188;
    localparam logic [8:0] OFF_WAKE  = 9'h18c;
    localparam logic [8:0] OFF_IST   = 9'h1c0;
    localparam logic [8:0] OFF_IMSK  = 9'h1c4;
    // ========================================================
    // field positions
    localparam int CC_AINC  = 10;
    localparam int CC_COR   = 9;
    localparam int CC_WMODE = 8;
    localparam int CM_FRZ   = 2;
    localparam int CM_CLRX  = 1;
    localparam int CM_CLTX  = 0;
    localparam int PD_START = 16;
    // interrupt status bits
    localparam int IRQ_RXD  = 0;
    localparam int IRQ_PEND = 1;
    localparam int IRQ_NORESP = 2;
    localparam int IRQ_WAKE = 3;
    localparam int NIRQ     = 4;
    // ========================================================
    // counts and reset values
    localparam int         NCNT      = 38;
    localparam logic [5:0] LAST_TX   = 6'h0e;
    localparam logic [5:0] LAST_CNT  = 6'h25;
    localparam logic [8:0] QBIT_LAST = 9'h1ff; // 512 bit times
    localparam logic [31:0] RST_WORD = 32'h0;
    // ========================================================
    // carriers
    typedef struct packed {
        logic        read;
        logic        write;
        logic [8:0]  address;
        logic [31:0] writedata;
    } mcr_av_req_t;

    typedef struct packed {
        logic [NCNT-1:0] cnt_evt;
        logic            rx_data;
        logic            byte_tick;
        logic            rx_bit_tick;
        logic            wake;
        logic [7:0]      wake_class;
        logic            host_ack;
    } mcr_evt_t;
endpackage

//--- verification/tb_mcr_regs.sv
// tb_mcr_regs: self-checking bench for the counter and control registers
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_mcr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import mcr_pkg::*;
    // ========================================================
    // signals and bookkeeping
    logic           clk;
    logic           rst_n;
    mcr_av_req_t    av;
    logic [31:0]    readdata;
    logic           waitrequest;
    mcr_evt_t       ev;
    logic [6:0]     peek_block;
    logic           tx_hold;
    logic           host_not_responding_reply;
    logic           irq;
    int             fails = 0;
    int             compares = 0;
    int             cyc = 0;
    int             nresp_cnt = 0;
    int             hold_cnt = 0;
    logic [31:0]    expq[$];
    logic [31:0]    exp_v;
    logic [31:0]    r;
    logic [7:0]     cls;
    // rw registers and the read-only wake class first, then the ones with side effects
    logic [8:0]     offs [10] = '{OFF_CCTL, OFF_PEEK, OFF_IDLY, OFF_PAUSE,
        OFF_HTO, OFF_WAKE, OFF_IMSK, OFF_CDATA, OFF_CMGT, OFF_IST};
    logic [31:0]    msk [7] = '{32'h73f, 32'h7f, 32'hffffff, 32'hffff,
        32'hffffffff, 32'h0, 32'hf};

    mcr_regs mcr_regs_inst (
        .clk(clk), .rst_n(rst_n), .av(av), .readdata(readdata),
        .waitrequest(waitrequest), .ev(ev), .peek_block(peek_block),
        .tx_hold(tx_hold), .irq(irq),
        .host_not_responding_reply(host_not_responding_reply));

    // ========================================================
    // bus master: hold the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [8:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        av <= '{read: !w, write: w, address: a, writedata: d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        av.read <= 1'b0;
        av.write <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    // the expectation is queued before the request goes out
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic evt(input int i, input int n);
        repeat (n) begin
            @(posedge clk);
            ev.cnt_evt[i] <= 1'b1;
            @(posedge clk);
            ev.cnt_evt[i] <= 1'b0;
        end
    endtask
    task automatic wake(input logic [7:0] c, input logic ack);
        @(posedge clk);
        ev.wake <= 1'b1;
        ev.wake_class <= c;
        @(posedge clk);
        ev.wake <= 1'b0;
        ev.host_ack <= ack;
        @(posedge clk);
        ev.host_ack <= 1'b0;
    endtask
    task automatic final_report();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ========================================================
    // clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // monitor: read results, pulse counts and the hang limit
    always @(posedge clk) begin
        cyc++;
        if (host_not_responding_reply === 1'b1) nresp_cnt++;
        if (tx_hold === 1'b1) hold_cnt++;
        if (av.read && waitrequest === 1'b0) begin
            exp_v = expq.pop_front();
            `CHK(readdata, exp_v)
        end
        if (cyc == 6000) begin
            fails++;
            final_report();
        end
    end

    // ========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        av = '0;
        ev = '0;
        void'($urandom(32'h7786ec9b));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped place, rw and read-only fields
        for (int i = 0; i < 10; i++) rd(offs[i], 32'h0);
        rd(9'h1fc, 32'h0);
        wr(9'h1fc, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            r = $urandom() & 32'hfffeffff;
            wr(offs[i], r);
            rd(offs[i], r & msk[i]);
        end
        wr(OFF_PEEK, 32'h5a);
        #1 `CHK(peek_block, 7'h5a)
        // counter read, write mode, clear on read, auto increment
        wr(OFF_CCTL, 32'h3);
        evt(3, 2);
        rd(OFF_CDATA, 32'h2);
        r = $urandom();
        wr(OFF_CCTL, 32'h103);
        wr(OFF_CDATA, r);
        wr(OFF_CCTL, 32'h603);
        rd(OFF_CDATA, r);
        rd(OFF_CCTL, 32'h604);
        rd(OFF_CDATA, 32'h0);
        wr(OFF_CCTL, 32'h3);
        rd(OFF_CDATA, 32'h0);
        wr(OFF_CCTL, 32'h425);
        rd(OFF_CDATA, 32'h0);
        rd(OFF_CCTL, 32'h400);
        // freeze queues events and applies them on release
        wr(OFF_CCTL, 32'h10);
        wr(OFF_CMGT, 32'h4);
        evt(16, 3);
        rd(OFF_CDATA, 32'h0);
        rd(OFF_CMGT, 32'h4);
        wr(OFF_CMGT, 32'h0);
        repeat (5) @(posedge clk);
        rd(OFF_CDATA, 32'h3);
        // bulk clears hit only their own direction
        evt(14, 1);
        evt(15, 1);
        wr(OFF_CMGT, 32'h2);
        rd(OFF_CMGT, 32'h0);
        wr(OFF_CCTL, 32'he);
        rd(OFF_CDATA, 32'h1);
        wr(OFF_CCTL, 32'hf);
        rd(OFF_CDATA, 32'h0);
        wr(OFF_CMGT, 32'h1);
        wr(OFF_CCTL, 32'he);
        rd(OFF_CDATA, 32'h0);
        // delayed receive interrupt waits for byte times; masked here
        wr(OFF_IMSK, 32'h2);
        wr(OFF_IST, 32'hf);
        wr(OFF_IDLY, 32'h3);
        @(posedge clk);
        ev.rx_data <= 1'b1;
        @(posedge clk);
        ev.rx_data <= 1'b0;
        repeat (10) @(posedge clk);
        rd(OFF_IST, 32'h0);
        ev.byte_tick <= 1'b1;
        repeat (10) @(posedge clk);
        rd(OFF_IST, 32'h1);
        `CHK(irq, 1'b0)
        wr(OFF_IST, 32'h1);
        // zero delay: status follows two edges after the event
        wr(OFF_IDLY, 32'h0);
        ev.rx_data <= 1'b1;
        @(posedge clk);
        ev.rx_data <= 1'b0;
        repeat (3) @(posedge clk);
        rd(OFF_IST, 32'h1);
        wr(OFF_IST, 32'h1);
        // local pause of one quantum, bit tick every cycle
        ev.rx_bit_tick <= 1'b1;
        hold_cnt = 0;
        wr(OFF_PAUSE, 32'h10001);
        @(posedge clk);
        #1 `CHK(tx_hold, 1'b1)
        rd(OFF_PAUSE, 32'h1);
        repeat (600) @(posedge clk);
        `CHK(hold_cnt inside {[512:514]}, 1'b1)
        `CHK(irq, 1'b1)
        rd(OFF_IST, 32'h2);
        wr(OFF_IST, 32'h2);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        // wake class capture and host reply watchdog
        cls = $urandom();
        wr(OFF_HTO, 32'h6);
        nresp_cnt = 0;
        wake(cls, 1'b0);
        `CHK(nresp_cnt, 0)
        repeat (15) @(posedge clk);
        `CHK(nresp_cnt, 1)
        rd(OFF_WAKE, {24'h0, cls});
        wake(~cls, 1'b1);
        repeat (20) @(posedge clk);
        `CHK(nresp_cnt, 1)
        rd(OFF_WAKE, {24'h0, ~cls});
        // zero timeout: the reply follows two edges after the wake
        wr(OFF_HTO, 32'h0);
        wake(cls, 1'b0);
        repeat (3) @(posedge clk);
        `CHK(nresp_cnt, 2)
        repeat (3) @(posedge clk);
        final_report();
    end
endmodule
